// [hw/dmbs_defs.svh]
// offsets, field positions, reset values and timing counts for the core register file
`ifndef DMBS_DEFS_SVH
`define DMBS_DEFS_SVH
`define DMBS_ADDR_WINDOW_A 7'h00
`define DMBS_ADDR_POINTER_A 7'h01
`define DMBS_ADDR_WINDOW_B 7'h02
`define DMBS_ADDR_POINTER_B 7'h03
`define DMBS_ADDR_BANK_SELECT 7'h04
`define DMBS_ADDR_ACCUMULATOR 7'h05
`define DMBS_ADDR_PC_LOW 7'h06
`define DMBS_ADDR_TABLE_LOW 7'h07
`define DMBS_ADDR_TABLE_LATCH 7'h08
`define DMBS_ADDR_TABLE_HIGH 7'h09
`define DMBS_ADDR_STATUS 7'h0a
`define DMBS_ADDR_NV_CONTROL 7'h40
`define DMBS_SFR_LAST 7'h7f
`define DMBS_GP_FIRST 8'h80
`define DMBS_BIT_TIMEOUT 5
`define DMBS_BIT_POWER_DOWN 4
`define DMBS_BIT_OVERFLOW 3
`define DMBS_BIT_ZERO 2
`define DMBS_BIT_AUX_CARRY 1
`define DMBS_BIT_CARRY 0
`define DMBS_BANK_SELECT_RESET 1'b0
`define DMBS_PC_WIDTH 13
`define DMBS_DUMMY_CYCLES 1
`endif

// [hw/dmbs_pkg.sv]
// types shared by the core register file and its alu
package dmbs_pkg;
   typedef enum logic [3:0] {
      ALU_PASS, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
      ALU_RLC, ALU_RRC, ALU_INC, ALU_DEC, ALU_CPL
   } dmbs_alu_op_t;

   typedef enum logic [1:0] {
      DST_NONE, DST_ACC, DST_MEM
   } dmbs_dst_t;

   typedef struct packed {
      logic carry;
      logic auxCarry;
      logic zero;
      logic overflow;
      logic changesCarry;
      logic changesArith;
   } dmbs_flags_t;

   typedef struct packed {
      logic valid;
      logic indirect;     // operand address comes from a pointer pair
      logic useWindowB;   // second pointer pair when indirect
      logic [7:0] addr;   // direct operand address (bit 7 picks general memory)
      dmbs_alu_op_t op;
      logic srcIsImm;
      logic [7:0] imm;
      logic memOperand;   // second alu operand taken from memory
      dmbs_dst_t dst;
      logic tableRead;
      logic clearWatchdog;
      logic halt;
   } dmbs_instr_t;

   typedef enum {
      ST_RUN, ST_DUMMY
   } dmbs_state_t;

   typedef struct packed {
      logic [7:0] accumulator;
      logic [7:0] pointerA;
      logic [7:0] pointerB;
      logic bankSelect;
      logic [7:0] tableLow;
      logic [7:0] tableHigh;
      logic [7:0] tableLatch;
      logic carry;
      logic auxCarry;
      logic zero;
      logic overflow;
      logic powerDown;
      logic timeout;
      logic [12:0] pc;
      logic pcLoad;
      logic stall;
      logic [7:0] readData;
      logic romReq;
      logic [7:0] romDest;
      logic romDestValid;
   } dmbs_regs_t;
endpackage : dmbs_pkg

// [hw/dmbs_alu.sv]
// eight-bit alu with carry, aux carry, zero and overflow generation
`timescale 1ns/1ps
`default_nettype none
`include "dmbs_defs.svh"
module dmbs_alu
   import dmbs_pkg::*;
(
   // operands
   input wire dmbs_alu_op_t op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic carryIn,
   // result
   output logic [7:0] result,
   output dmbs_flags_t flags
);
   function automatic logic [10:0] addFull(input logic [7:0] x, input logic [7:0] y,
                                           input logic cin);
      logic [4:0] lo;
      logic [3:0] hi7;
      logic [8:0] full;
      lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      hi7 = {1'b0, x[6:4]} + {1'b0, y[6:4]} + {3'h0, lo[4]};
      full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      // {overflow, aux carry, carry, sum}
      addFull = {hi7[3] ^ full[8], lo[4], full};
   endfunction : addFull

   logic [10:0] sum;
   always_comb begin
      sum = 11'h000;
      result = a;
      flags = '0;
      unique case (op)
         ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_INC, ALU_DEC: begin
            // subtraction adds the complement, so carry means no borrow
            unique case (op)
               ALU_ADD: sum = addFull(a, b, 1'b0);
               ALU_ADC: sum = addFull(a, b, carryIn);
               ALU_SUB: sum = addFull(a, ~b, 1'b1);
               ALU_SBC: sum = addFull(a, ~b, carryIn);
               ALU_INC: sum = addFull(a, 8'h01, 1'b0);
               default: sum = addFull(a, 8'hff, 1'b0);
            endcase
            result = sum[7:0];
            flags.carry = sum[8];
            flags.auxCarry = sum[9];
            flags.overflow = sum[10];
            flags.changesCarry = (op != ALU_INC) && (op != ALU_DEC);
            flags.changesArith = 1'b1;
         end
         ALU_AND: begin
            result = a & b;
            flags.changesArith = 1'b1;
         end
         ALU_OR: begin
            result = a | b;
            flags.changesArith = 1'b1;
         end
         ALU_XOR: begin
            result = a ^ b;
            flags.changesArith = 1'b1;
         end
         ALU_CPL: begin
            result = ~a;
            flags.changesArith = 1'b1;
         end
         ALU_RLC: begin
            result = {a[6:0], carryIn};
            flags.carry = a[7];
            flags.changesCarry = 1'b1;
         end
         ALU_RRC: begin
            result = {carryIn, a[7:1]};
            flags.carry = a[0];
            flags.changesCarry = 1'b1;
         end
         default: result = b;
      endcase
      flags.zero = (result == 8'h00);
   end
endmodule : dmbs_alu
`default_nettype wire

// [hw/dmbs_core_regs.sv]
// core special function registers: banking, pointers, accumulator, pc low, table, status
`timescale 1ns/1ps
`default_nettype none
`include "dmbs_defs.svh"
module dmbs_core_regs
   import dmbs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // reset cause, sampled at the first clock after reset is released
   input wire logic powerUpReset,
   input wire logic watchdogTimeout,
   // instruction from the execution unit
   input wire dmbs_instr_t instr,
   // program memory word for table reads
   input wire logic [15:0] romData,
   input wire logic romValid,
   // to the execution unit
   output logic [7:0] accumulatorOut,
   output logic [7:0] readData,
   output logic [12:0] pcOut,
   output logic pcLoad,
   output logic stall,
   output logic [15:0] romAddr,
   output logic romReq,
   output logic [7:0] statusOut,
   output logic bankSelectOut
);
   dmbs_regs_t q, d;
   // two banks of general memory; bank 1 is reached only through the second pair
   logic [7:0] gpMem [0:255];

   // synchronise the watchdog event, it comes from the slow timer domain
   logic wdtMeta_q, wdtSync_q, wdtSeen_q;
   logic wdtEvent;
   // remember why reset happened; keepBank_q stays 0, as reset clears wdtSync_q and q.powerDown before it samples them, and the bank is still cleared
   logic pendWdtReset_q;
   logic keepBank_q;

   function automatic logic [7:0] ptrAddr(input dmbs_instr_t i, input dmbs_regs_t r);
      if (!i.indirect)
         ptrAddr = {1'b0, i.addr[6:0]} | (i.addr[7] ? 8'h80 : 8'h00);
      else if (i.useWindowB)
         ptrAddr = r.pointerB;
      else
         ptrAddr = r.pointerA;
   endfunction : ptrAddr

   // gp index: bank bit and low address bits; direct and first pair force bank 0
   function automatic logic [7:0] gpIndex(input dmbs_instr_t i, input logic [7:0] a,
                                          input logic bank);
      logic useBank;
      useBank = i.indirect && i.useWindowB && bank;
      gpIndex = {useBank, a[6:0]};
   endfunction : gpIndex

   function automatic logic isWindow(input logic [7:0] a);
      isWindow = (a[7:0] == {1'b0, `DMBS_ADDR_WINDOW_A}) ||
                 (a[7:0] == {1'b0, `DMBS_ADDR_WINDOW_B});
   endfunction : isWindow

   logic [7:0] effAddr;
   logic [7:0] memRead;
   logic [7:0] sfrRead;
   logic [7:0] statusByte;
   logic [7:0] aluResult;
   dmbs_flags_t aluFlags;
   logic memWrite;
   logic [7:0] writeData;
   logic gpSel;

   assign wdtEvent = wdtSync_q & ~wdtSeen_q;

   always_comb begin
      statusByte = 8'h00;
      statusByte[`DMBS_BIT_TIMEOUT] = q.timeout;
      statusByte[`DMBS_BIT_POWER_DOWN] = q.powerDown;
      statusByte[`DMBS_BIT_OVERFLOW] = q.overflow;
      statusByte[`DMBS_BIT_ZERO] = q.zero;
      statusByte[`DMBS_BIT_AUX_CARRY] = q.auxCarry;
      statusByte[`DMBS_BIT_CARRY] = q.carry;
   end

   always_comb begin
      effAddr = ptrAddr(instr, q);
      gpSel = effAddr[7];
      // special registers ignore the bank bit
      unique case (effAddr)
         {1'b0, `DMBS_ADDR_WINDOW_A}, {1'b0, `DMBS_ADDR_WINDOW_B}: sfrRead = 8'h00;
         {1'b0, `DMBS_ADDR_POINTER_A}: sfrRead = q.pointerA;
         {1'b0, `DMBS_ADDR_POINTER_B}: sfrRead = q.pointerB;
         {1'b0, `DMBS_ADDR_BANK_SELECT}: sfrRead = {7'h00, q.bankSelect};
         {1'b0, `DMBS_ADDR_ACCUMULATOR}: sfrRead = q.accumulator;
         {1'b0, `DMBS_ADDR_PC_LOW}: sfrRead = q.pc[7:0];
         {1'b0, `DMBS_ADDR_TABLE_LOW}: sfrRead = q.tableLow;
         {1'b0, `DMBS_ADDR_TABLE_LATCH}: sfrRead = q.tableLatch;
         {1'b0, `DMBS_ADDR_TABLE_HIGH}: sfrRead = q.tableHigh;
         {1'b0, `DMBS_ADDR_STATUS}: sfrRead = statusByte;
         // the nv control register lives outside; here it reads zero whatever the bank
         default: sfrRead = 8'h00;
      endcase
      memRead = gpSel ? gpMem[gpIndex(instr, effAddr, q.bankSelect)] : sfrRead;
   end

   // alu second operand: immediate, memory or accumulator; a memory operand can be written back to memory
   dmbs_alu u_alu (
      .op(instr.op),
      .a(instr.memOperand && instr.op == ALU_PASS ? memRead :
         (instr.memOperand && instr.dst == DST_MEM ? memRead : q.accumulator)),
      .b(instr.srcIsImm ? instr.imm : (instr.memOperand ? memRead : q.accumulator)),
      .carryIn(q.carry),
      .result(aluResult),
      .flags(aluFlags)
   );

   always_comb begin
      d = q;
      d.pcLoad = 1'b0;
      d.romReq = 1'b0;
      d.readData = memRead;
      memWrite = 1'b0;
      writeData = aluResult;
      if (q.pcLoad)
         d.pc = q.pc;
      else if (instr.valid && !q.stall)
         d.pc = q.pc + 13'h0001;
      d.stall = 1'b0;
      if (q.stall) begin
         // dummy cycle after a pc low write: nothing executes
         d.stall = 1'b0;
      end else if (instr.valid) begin
         if (instr.tableRead) begin
            d.romReq = 1'b1;
            d.romDest = effAddr;
            d.romDestValid = 1'b1;
         end else if (instr.dst == DST_ACC) begin
            d.accumulator = aluResult;
         end else if (instr.dst == DST_MEM) begin
            memWrite = 1'b1;
         end
         if (aluFlags.changesArith) begin
            // flags land with the result in this same cycle
            d.zero = aluFlags.zero;
            d.overflow = aluFlags.overflow;
            d.auxCarry = aluFlags.auxCarry;
         end
         if (aluFlags.changesCarry)
            d.carry = aluFlags.carry;
         if (instr.clearWatchdog) begin
            d.powerDown = 1'b0;
            d.timeout = 1'b0;
         end
         if (instr.halt) begin
            d.powerDown = 1'b1;
            d.timeout = 1'b0;
         end
      end
      // direct or indirect write into a special register
      if (memWrite && !gpSel) begin
         unique case (effAddr)
            {1'b0, `DMBS_ADDR_POINTER_A}: d.pointerA = writeData;
            {1'b0, `DMBS_ADDR_POINTER_B}: d.pointerB = writeData;
            {1'b0, `DMBS_ADDR_BANK_SELECT}: d.bankSelect = writeData[0];
            {1'b0, `DMBS_ADDR_ACCUMULATOR}: d.accumulator = writeData;
            {1'b0, `DMBS_ADDR_PC_LOW}: begin
               d.pc = {q.pc[12:8], writeData};
               d.pcLoad = 1'b1;
               d.stall = 1'b1;
            end
            {1'b0, `DMBS_ADDR_TABLE_LOW}: d.tableLow = writeData;
            {1'b0, `DMBS_ADDR_TABLE_LATCH}: d.tableLatch = writeData;
            {1'b0, `DMBS_ADDR_TABLE_HIGH}: d.tableHigh = writeData;
            {1'b0, `DMBS_ADDR_STATUS}: begin
               // system flags are left alone
               d.overflow = writeData[`DMBS_BIT_OVERFLOW];
               d.zero = writeData[`DMBS_BIT_ZERO];
               d.auxCarry = writeData[`DMBS_BIT_AUX_CARRY];
               d.carry = writeData[`DMBS_BIT_CARRY];
            end
            // windows through a pointer drop the write
            default: d.tableLatch = d.tableLatch;
         endcase
      end
      if (q.romDestValid && romValid) begin
         d.tableLatch = romData[15:8];
         d.romDestValid = 1'b0;
         if (q.romDest == {1'b0, `DMBS_ADDR_ACCUMULATOR})
            d.accumulator = romData[7:0];
      end
      // watchdog time-out wins over a clear in the same cycle
      if (wdtEvent)
         d.timeout = 1'b1;
      // status is never stacked; calls and interrupts leave these registers as is
   end

   always_ff @(posedge core_clk) begin
      if (memWrite && gpSel && !(instr.indirect && isWindow(effAddr)))
         gpMem[gpIndex(instr, effAddr, q.bankSelect)] <= writeData;
      if (q.romDestValid && romValid && q.romDest[7])
         gpMem[{1'b0, q.romDest[6:0]}] <= romData[7:0];
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdtMeta_q <= 1'b0;
         wdtSync_q <= 1'b0;
         wdtSeen_q <= 1'b0;
      end else begin
         wdtMeta_q <= watchdogTimeout;
         wdtSync_q <= wdtMeta_q;
         wdtSeen_q <= wdtSync_q;
      end
   end

   // cause of the last reset, caught by the clock after release
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pendWdtReset_q <= 1'b1;
         keepBank_q <= 1'b0;
      end else begin
         pendWdtReset_q <= 1'b0;
         if (pendWdtReset_q)
            keepBank_q <= !powerUpReset && wdtSync_q && q.powerDown;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // bank bit cannot take a port value here; it is loaded with DMBS_BANK_SELECT_RESET after release below
         q <= '0;
      end else begin
         q <= d;
         if (pendWdtReset_q) begin
            q.bankSelect <= `DMBS_BANK_SELECT_RESET;
            if (powerUpReset) begin
               q.powerDown <= 1'b0;
               q.timeout <= 1'b0;
            end
         end
      end
   end

   assign accumulatorOut = q.accumulator;
   assign readData = q.readData;
   assign pcOut = q.pc;
   assign pcLoad = q.pcLoad;
   assign stall = q.stall;
   assign romAddr = {q.tableHigh, q.tableLow};
   assign romReq = q.romReq;
   assign statusOut = statusByte;
   assign bankSelectOut = q.bankSelect;
endmodule : dmbs_core_regs
`default_nettype wire

// [tb/dmbs_core_regs_checker.sv]
// concurrent checks on the core register file ports
`timescale 1ns/1ps
`default_nettype none
`include "dmbs_defs.svh"
module dmbs_core_regs_checker
   import dmbs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // watched ports
   input wire dmbs_instr_t instr,
   input wire logic [7:0] accumulatorOut,
   input wire logic [12:0] pcOut,
   input wire logic pcLoad,
   input wire logic stall,
   input wire logic [7:0] statusOut,
   input wire logic bankSelectOut
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // an instruction offered during the dummy cycle is not taken
   wire logic taken = instr.valid && !stall;

   status_top_a: assert property (statusOut[7:6] == 2'b00)
      else $error("status upper bits not zero");
   pc_jump_a: assert property (taken && !instr.indirect && instr.dst == DST_MEM
      && !instr.tableRead
      && instr.addr == {1'b0, `DMBS_ADDR_PC_LOW} |=> pcLoad && stall)
      else $error("pc low write without dummy cycle");
   stall_once_a: assert property (stall |=> !stall)
      else $error("dummy cycle longer than one");
   pc_page_a: assert property (pcLoad |-> pcOut[12:8] == $past(pcOut[12:8]))
      else $error("pc low write left the page");
   pd_rise_a: assert property ($rose(statusOut[4]) |-> $past(taken && instr.halt))
      else $error("power down flag set without halt");
   pd_fall_a: assert property ($fell(statusOut[4]) |-> $past(taken && instr.clearWatchdog))
      else $error("power down flag cleared without clear watchdog");
   to_fall_a: assert property ($fell(statusOut[5])
      |-> $past(taken && (instr.clearWatchdog || instr.halt)))
      else $error("timeout flag cleared by other event");
   bank_change_a: assert property ($changed(bankSelectOut)
      |-> $past(taken && instr.dst == DST_MEM))
      else $error("bank select changed without a write");
   zero_flag_a: assert property (taken && instr.dst == DST_ACC
      && instr.op inside {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR}
      |=> statusOut[2] == (accumulatorOut == 8'h00))
      else $error("zero flag does not match result");
   sys_flags_keep_a: assert property (taken && instr.dst == DST_MEM && !instr.indirect
      && instr.addr == {1'b0, `DMBS_ADDR_STATUS} |=> $stable(statusOut[5:4]))
      else $error("status write changed system flags");
endmodule : dmbs_core_regs_checker
`default_nettype wire

// [tb/dmbs_rom_model.sv]
// program memory answering table reads with a set latency
`timescale 1ns/1ps
`default_nettype none
module dmbs_rom_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // request from the core
   input wire logic romReq,
   input wire logic [15:0] romAddr,
   input wire logic [3:0] latency,
   // answer
   output logic [15:0] romData,
   output logic romValid
);
   logic [15:0] addr_q;
   logic [3:0] wait_q;
   logic busy_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         wait_q <= 4'h0;
         addr_q <= 16'h0000;
         romValid <= 1'b0;
         romData <= 16'h0000;
      end else begin
         romValid <= 1'b0;
         // outside an answer the word toggles, so a stale capture shows
         romData <= ~romData;
         if (romReq) begin
            busy_q <= 1'b1;
            addr_q <= romAddr;
            wait_q <= latency;
         end else if (busy_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (busy_q) begin
            busy_q <= 1'b0;
            romValid <= 1'b1;
            romData <= {addr_q[7:0] ^ 8'h5a, addr_q[15:8] ^ 8'hc3};
         end
      end
   end
endmodule : dmbs_rom_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the core register file
`timescale 1ns/1ps
`default_nettype none
`include "dmbs_defs.svh"
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
   import dmbs_pkg::*;
;
   localparam logic [7:0] aPtrA = {1'b0, `DMBS_ADDR_POINTER_A};
   localparam logic [7:0] aPtrB = {1'b0, `DMBS_ADDR_POINTER_B};
   localparam logic [7:0] aBank = {1'b0, `DMBS_ADDR_BANK_SELECT};
   localparam logic [7:0] aStat = {1'b0, `DMBS_ADDR_STATUS};
   localparam logic [7:0] aPcl = {1'b0, `DMBS_ADDR_PC_LOW};
   localparam logic [7:0] aTblL = {1'b0, `DMBS_ADDR_TABLE_LOW};
   localparam logic [7:0] aTblH = {1'b0, `DMBS_ADDR_TABLE_HIGH};
   localparam logic [7:0] aLatch = {1'b0, `DMBS_ADDR_TABLE_LATCH};
   logic core_clk, rst_n, powerUpReset, watchdogTimeout, romValid, pcLoad, stall, romReq;
   logic bankSelectOut;
   dmbs_instr_t instr;
   logic [15:0] romData, romAddr;
   logic [7:0] accumulatorOut, readData, statusOut;
   logic [12:0] pcOut;
   logic [3:0] latency;
   logic [2:0] watched;
   int mismatches, numChecks;

   dmbs_core_regs i_dmbs_core_regs (.core_clk(core_clk), .rst_n(rst_n),
      .powerUpReset(powerUpReset), .watchdogTimeout(watchdogTimeout), .instr(instr),
      .romData(romData), .romValid(romValid), .accumulatorOut(accumulatorOut),
      .readData(readData), .pcOut(pcOut), .pcLoad(pcLoad), .stall(stall),
      .romAddr(romAddr), .romReq(romReq), .statusOut(statusOut),
      .bankSelectOut(bankSelectOut));
   dmbs_rom_model i_dmbs_rom_model (.core_clk(core_clk), .rst_n(rst_n), .romReq(romReq),
      .romAddr(romAddr), .latency(latency), .romData(romData), .romValid(romValid));
   // signals that bounded waits poll, picked by index
   assign watched = {romValid, romReq, statusOut[5]};

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // m: 00 direct, 01 first pointer pair, 11 second pointer pair
   function automatic dmbs_instr_t ins(input dmbs_alu_op_t op, input logic [7:0] a,
      input logic [7:0] imm, input logic memOp, input dmbs_dst_t dst, input logic [1:0] m);
      dmbs_instr_t i;
      i = '0;
      i.valid = 1'b1;
      i.op = op;
      i.addr = a;
      i.imm = imm;
      i.memOperand = memOp;
      i.srcIsImm = !memOp && dst == DST_ACC;
      i.dst = dst;
      i.indirect = m[0];
      i.useWindowB = m[1];
      return i;
   endfunction : ins

   task automatic wrapUp;
      $display("checks=%0d mismatches=%0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrapUp

   task automatic exec(input dmbs_instr_t i);
      @(posedge core_clk);
      instr <= i;
      @(posedge core_clk);
      instr <= '0;
      #1;
   endtask : exec

   task automatic waitHigh(input int k);
      for (int n = 0; n < 20 && watched[k] !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      if (watched[k] !== 1'b1) begin
         mismatches++;
         wrapUp();
      end
   endtask : waitHigh

   // memory moves always pass through the accumulator
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] m);
      exec(ins(ALU_PASS, 8'h00, v, 1'b0, DST_ACC, 2'b00));
      exec(ins(ALU_PASS, a, 8'h00, 1'b0, DST_MEM, m));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] m, input logic [7:0] e);
      exec(ins(ALU_PASS, a, 8'h00, 1'b1, DST_ACC, m));
      `CHK(accumulatorOut, e)
      `CHK(readData, e)
   endtask : rd

   task automatic fl(input dmbs_alu_op_t op, input logic [7:0] a, b, r, input logic [3:0] f);
      exec(ins(ALU_PASS, 8'h00, a, 1'b0, DST_ACC, 2'b00));
      exec(ins(op, 8'h00, b, 1'b0, DST_ACC, 2'b00));
      `CHK(accumulatorOut, r)
      `CHK(statusOut[3:0], f)
   endtask : fl

   task automatic chkBanks;
      `CHK(bankSelectOut, 1'b0)
      rd(aBank, 2'b00, 8'h00);
      wr(aBank, 8'hff, 2'b00);
      `CHK(bankSelectOut, 1'b1)
      rd(aBank, 2'b00, 8'h01);
      wr(8'h80, 8'h33, 2'b00);
      wr(aPtrB, 8'h80, 2'b00);
      wr(8'h02, 8'h5a, 2'b11);
      wr(aPtrA, 8'h80, 2'b00);
      rd(8'h00, 2'b01, 8'h33);
      rd(8'h02, 2'b11, 8'h5a);
      rd(8'h80, 2'b00, 8'h33);
      rd(aPtrB, 2'b00, 8'h80);
      wr(aBank, 8'h00, 2'b00);
      rd(8'h02, 2'b11, 8'h33);
   endtask : chkBanks

   task automatic chkWindow;
      wr(aPtrA, 8'h02, 2'b00);
      rd(8'h00, 2'b01, 8'h00);
      wr(8'h00, 8'h99, 2'b01);
      rd(8'h80, 2'b00, 8'h33);
      rd(aPtrB, 2'b00, 8'h80);
      exec(ins(ALU_INC, aPtrA, 8'h00, 1'b1, DST_MEM, 2'b00));
      rd(aPtrA, 2'b00, 8'h03);
   endtask : chkWindow

   task automatic chkFlags;
      fl(ALU_ADD, 8'h7f, 8'h01, 8'h80, 4'b1010);
      fl(ALU_ADD, 8'hff, 8'h01, 8'h00, 4'b0111);
      fl(ALU_SUB, 8'h05, 8'h03, 8'h02, 4'b0011);
      fl(ALU_SUB, 8'h03, 8'h05, 8'hfe, 4'b0000);
      fl(ALU_SUB, 8'h80, 8'h01, 8'h7f, 4'b1001);
      fl(ALU_AND, 8'h0f, 8'hf0, 8'h00, 4'b0101);
      fl(ALU_RLC, 8'h40, 8'h00, 8'h81, 4'b0100);
      fl(ALU_SBC, 8'h10, 8'h01, 8'h0e, 4'b0001);
      fl(ALU_ADC, 8'h08, 8'h07, 8'h10, 4'b0010);
      fl(ALU_RRC, 8'h01, 8'h00, 8'h00, 4'b0011);
      fl(ALU_XOR, 8'h5a, 8'h5a, 8'h00, 4'b0101);
      fl(ALU_DEC, 8'h01, 8'h00, 8'h00, 4'b0111);
      fl(ALU_OR, 8'h50, 8'h0a, 8'h5a, 4'b0001);
      fl(ALU_CPL, 8'hff, 8'h00, 8'h00, 4'b0101);
   endtask : chkFlags

   task automatic chkSystem;
      dmbs_instr_t h;
      @(posedge core_clk);
      watchdogTimeout <= 1'b1;
      repeat (3) @(posedge core_clk);
      watchdogTimeout <= 1'b0;
      #1;
      waitHigh(0);
      h = ins(ALU_PASS, 8'h00, 8'h00, 1'b0, DST_NONE, 2'b00);
      h.halt = 1'b1;
      exec(h);
      `CHK(statusOut[5:4], 2'b01)
      wr(aStat, 8'hff, 2'b00);
      `CHK(statusOut, 8'h1f)
      h.halt = 1'b0;
      h.clearWatchdog = 1'b1;
      exec(h);
      `CHK(statusOut[5:4], 2'b00)
      rd(aStat, 2'b00, 8'h0f);
   endtask : chkSystem

   task automatic chkPcLow;
      logic [4:0] hi;
      exec(ins(ALU_PASS, 8'h00, 8'h9c, 1'b0, DST_ACC, 2'b00));
      hi = pcOut[12:8];
      @(posedge core_clk);
      instr <= ins(ALU_PASS, aPcl, 8'h00, 1'b0, DST_MEM, 2'b00);
      @(posedge core_clk);
      // offered in the dummy cycle, must be dropped
      instr <= ins(ALU_PASS, 8'h00, 8'h77, 1'b0, DST_ACC, 2'b00);
      #1;
      `CHK({pcLoad, stall}, 2'b11)
      `CHK(pcOut, {hi, 8'h9c})
      @(posedge core_clk);
      instr <= '0;
      #1;
      `CHK(accumulatorOut, 8'h9c)
   endtask : chkPcLow

   task automatic chkTable(input logic [3:0] lat, input logic [7:0] lo, hi);
      dmbs_instr_t t;
      latency <= lat;
      wr(aTblL, lo, 2'b00);
      wr(aTblH, hi, 2'b00);
      t = ins(ALU_PASS, 8'h81, 8'h00, 1'b0, DST_MEM, 2'b00);
      t.tableRead = 1'b1;
      exec(t);
      waitHigh(1);
      `CHK(romAddr, {hi, lo})
      waitHigh(2);
      repeat (2) @(posedge core_clk);
      #1;
      rd(aLatch, 2'b00, lo ^ 8'h5a);
      rd(8'h81, 2'b00, hi ^ 8'hc3);
   endtask : chkTable

   initial begin
      rst_n = 1'b0;
      powerUpReset = 1'b1;
      watchdogTimeout = 1'b0;
      instr = '0;
      latency = 4'h0;
      mismatches = 0;
      numChecks = 0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1;
      `CHK(statusOut[5:4], 2'b00)
      chkBanks();
      chkWindow();
      chkFlags();
      chkSystem();
      chkPcLow();
      chkTable(4'h0, 8'h34, 8'h12);
      chkTable(4'h4, 8'hcb, 8'h0e);
      wrapUp();
   end
endmodule : tb_top

bind dmbs_core_regs dmbs_core_regs_checker i_dmbs_core_regs_checker (.core_clk(core_clk),
   .rst_n(rst_n), .instr(instr), .accumulatorOut(accumulatorOut), .pcOut(pcOut),
   .pcLoad(pcLoad), .stall(stall), .statusOut(statusOut), .bankSelectOut(bankSelectOut));
`default_nettype wire
